// >>> drive_limit_cfg.svh
// constants of the limit warning, initial ramp and fill sequencer
// assumes one 125 MHz clock and a 32-bit classic wishbone slave port
// Operation
// - reference-low warning while remote reference is below the lower reference limit
// - reference-high warning while resulting reference is above the upper reference limit
// - both reference comparisons only act when remote reference is selected
// - feedback-low warning while feedback is below the feedback floor
// - feedback-high warning while feedback is above the feedback ceiling
// - warnings are suppressed during ramp-up, ramp-down and standstill
// - warnings enable only once output frequency has reached its reference
// - each warning can be routed to the signal terminal and the relays
// - feedback floor accepts -999,999.999 up to the current feedback ceiling
// - initial ramp brings motor to minimum speed, then normal ramp-up takes over
// - initial ramp time is 000.1 s to 360.0 s in 0.1 s steps
// - initial ramp time 000.0 means off and normal ramp-up is used
// - fill mode needs closed loop, nonzero fill rate and normal regulator direction
// - fill mode starts when output reaches minimum frequency after start
// - fill samples feedback, then ramps pressure target at fill rate to filled setpoint
// - when feedback reaches filled setpoint, switch to operating setpoint one or two
// - fill rate is off or 0.001 to 999999.999 units per second in .001 steps
// - filled setpoint is bounded by minimum feedback and maximum reference, .01 steps
`ifndef DRIVE_LIMIT_CFG_SVH
`define DRIVE_LIMIT_CFG_SVH
`define ADR_CTRL 8'h00
`define ADR_STATUS 8'h04
`define ADR_IRQ_STAT 8'h08
`define ADR_IRQ_MASK 8'h0c
`define ADR_REF_LOW 8'h10
`define ADR_REF_HIGH 8'h14
`define ADR_FB_FLOOR 8'h18
`define ADR_FB_CEIL 8'h1c
`define ADR_INIT_RAMP 8'h20
`define ADR_MIN_FREQ 8'h24
`define ADR_FILL_RATE 8'h28
`define ADR_FILLED_SP 8'h2c
`define ADR_SP1 8'h30
`define ADR_SP2 8'h34
`define ADR_FB_MIN 8'h38
`define ADR_REF_MAX 8'h3c
`define ADR_ROUTE 8'h40
`define CTRL_START 0
`define CTRL_REMOTE 1
`define CTRL_CLOSED 2
`define CTRL_INVERSE 3
`define CTRL_SP2 4
`define VAL_MIN 32'shc4653601
`define VAL_MAX 32'sh3b9ac9ff
`define INIT_RAMP_MAX 32'sh00000e10
`define SP_STEP 32'sh0000000a
`define CLK_MHZ 125
`define FILL_TICK_US 1000
`define FILL_TICK_CYC (`FILL_TICK_US * `CLK_MHZ)
`define MICRO_PER_MILLI 48'sh0000000003e8
`endif

// >>> drive_limit_pkg.sv
// types shared by the limit warning and fill sequencer
// assumes nothing beyond the constants header
package drive_limit_pkg;
    typedef enum logic [2:0] {
        ST_STOP, ST_INIT_RAMP, ST_RAMP_UP, ST_FILL, ST_RUN, ST_RAMP_DOWN
    } drive_state_t;
    typedef logic signed [31:0] value_t;
endpackage

// >>> drive_limit_warn_fill_ramp.sv
// limit warnings, initial ramp selection and pipe fill sequencing
// assumes reference, feedback and frequency inputs come from same-clock logic
//
// Added by the designer: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "drive_limit_cfg.svh"
module drive_limit_warn_fill_ramp
    import drive_limit_pkg::*;
#(
    parameter int FILL_TICK_CYC = `FILL_TICK_CYC
) (
    input wire logic clk_i,            // 125 MHz clock
    input wire logic rst_i,            // sync reset, high
    input wire logic ce_i,             // clock enable
    input wire logic cyc_i,            // wishbone cycle
    input wire logic stb_i,            // wishbone strobe
    input wire logic we_i,             // wishbone write
    input wire logic [7:0] adr_i,      // byte address
    input wire logic [31:0] dat_i,     // write data
    input wire logic [3:0] sel_i,      // byte enables
    output logic [31:0] dat_o,         // read data
    output logic ack_o,                // wishbone ack
    input wire value_t remote_ref_i,   // remote reference
    input wire value_t result_ref_i,   // resulting reference
    input wire value_t feedback_i,     // pressure feedback
    input wire value_t out_freq_i,     // output frequency
    input wire value_t freq_ref_i,     // frequency being tracked
    output logic ref_under_flag_o,     // reference low
    output logic ref_over_flag_o,      // reference high
    output logic feedback_under_flag_o, // feedback low
    output logic feedback_over_flag_o, // feedback high
    output logic term_o,               // signal output terminal
    output logic [1:0] relay_o,        // relay outputs
    output logic init_ramp_active_o,   // initial ramp rate in use
    output logic [11:0] init_ramp_time_o, // initial ramp, 0.1 s units
    output logic fill_active_o,        // fill mode running
    output value_t setpoint_o,         // regulator setpoint
    output logic irq_o                 // level interrupt
);

    ////////////////////////////////////////////////////////////////////
    // helpers

    function automatic value_t clampv(input value_t v, input value_t lo,
                                      input value_t hi);
        value_t r;
        r = v;
        if (v < lo) begin
            r = lo;
        end
        if (v > hi) begin
            r = hi;
        end
        return r;
    endfunction

    function automatic value_t merge(input value_t old, input logic [31:0] nw, input logic [3:0] be);
        value_t r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // register state

    logic [4:0] ctrl_reg;
    logic [4:0] irq_stat_reg;
    logic [4:0] irq_mask_reg;
    logic [11:0] route_reg;
    value_t ref_low_reg;
    value_t ref_high_reg;
    value_t fb_floor_reg;
    value_t fb_ceil_reg;
    value_t init_ramp_reg;
    value_t min_freq_reg;
    value_t fill_rate_reg;
    value_t filled_sp_reg;
    value_t sp1_reg;
    value_t sp2_reg;
    value_t fb_min_reg;
    value_t ref_max_reg;
    logic [31:0] dat_reg;
    logic ack_reg;
    logic [3:0] warn_reg;
    logic [3:0] warn_prev_reg;
    logic term_reg;
    logic [1:0] relay_reg;
    value_t setpoint_reg;
    drive_state_t state_reg;
    drive_state_t state_next;
    logic filled_once_reg;
    logic signed [47:0] target_reg;
    logic [31:0] tick_cnt_reg;

    ////////////////////////////////////////////////////////////////////
    // bus decode

    wire req = cyc_i & stb_i & ~ack_reg;
    wire wr = req & we_i;
    wire sel_ctrl = adr_i == `ADR_CTRL;
    wire sel_status = adr_i == `ADR_STATUS;
    wire sel_istat = adr_i == `ADR_IRQ_STAT;
    wire sel_imask = adr_i == `ADR_IRQ_MASK;
    wire sel_rlow = adr_i == `ADR_REF_LOW;
    wire sel_rhigh = adr_i == `ADR_REF_HIGH;
    wire sel_ffloor = adr_i == `ADR_FB_FLOOR;
    wire sel_fceil = adr_i == `ADR_FB_CEIL;
    wire sel_iramp = adr_i == `ADR_INIT_RAMP;
    wire sel_minf = adr_i == `ADR_MIN_FREQ;
    wire sel_frate = adr_i == `ADR_FILL_RATE;
    wire sel_fsp = adr_i == `ADR_FILLED_SP;
    wire sel_sp1 = adr_i == `ADR_SP1;
    wire sel_sp2 = adr_i == `ADR_SP2;
    wire sel_fbmin = adr_i == `ADR_FB_MIN;
    wire sel_rmax = adr_i == `ADR_REF_MAX;
    wire sel_route = adr_i == `ADR_ROUTE;

    // write data merged with the old word, then held inside legal ranges; w_generic takes dat_i whole, unclamped
    wire value_t w_rlow = clampv(merge(ref_low_reg, dat_i, sel_i), `VAL_MIN, ref_high_reg);
    wire value_t w_rhigh = clampv(merge(ref_high_reg, dat_i, sel_i), ref_low_reg, `VAL_MAX);
    wire value_t w_ffloor = clampv(merge(fb_floor_reg, dat_i, sel_i), `VAL_MIN, fb_ceil_reg);
    wire value_t w_fceil = clampv(merge(fb_ceil_reg, dat_i, sel_i), fb_floor_reg, `VAL_MAX);
    wire value_t w_iramp = clampv(merge(init_ramp_reg, dat_i, sel_i), 32'sh0, `INIT_RAMP_MAX);
    wire value_t w_frate = clampv(merge(fill_rate_reg, dat_i, sel_i), 32'sh0, `VAL_MAX);
    wire value_t w_fsp_raw = merge(filled_sp_reg, dat_i, sel_i);
    // snap to whole 0.01 steps before bounding
    wire value_t w_fsp_step = w_fsp_raw - (w_fsp_raw % `SP_STEP);
    wire value_t w_fsp = clampv(w_fsp_step, fb_min_reg, ref_max_reg);
    wire value_t w_generic = value_t'(dat_i);

    ////////////////////////////////////////////////////////////////////
    // operating conditions

    wire start_cmd = ctrl_reg[`CTRL_START];
    wire init_on = init_ramp_reg != 32'sh0;
    wire fill_ok = ctrl_reg[`CTRL_CLOSED] & (fill_rate_reg != 32'sh0)
                   & ~ctrl_reg[`CTRL_INVERSE];
    wire at_min = out_freq_i >= min_freq_reg;
    wire at_ref = out_freq_i == freq_ref_i;
    wire stopped = out_freq_i == 32'sh0;
    wire fill_reached = feedback_i >= filled_sp_reg;
    wire warn_en = state_reg == ST_RUN;
    wire remote_sel = ctrl_reg[`CTRL_REMOTE];
    wire tick = tick_cnt_reg == 32'(FILL_TICK_CYC - 1);
    wire signed [47:0] filled_fine = 48'(filled_sp_reg) * `MICRO_PER_MILLI;
    wire signed [47:0] target_step = target_reg + 48'(fill_rate_reg);
    wire value_t target_out = value_t'(target_reg / `MICRO_PER_MILLI);
    wire value_t op_sp = ctrl_reg[`CTRL_SP2] ? sp2_reg : sp1_reg;

    wire [3:0] warn_now;
    assign warn_now[0] = warn_en & remote_sel & (remote_ref_i < ref_low_reg);
    assign warn_now[1] = warn_en & remote_sel & (result_ref_i > ref_high_reg);
    assign warn_now[2] = warn_en & (feedback_i < fb_floor_reg);
    assign warn_now[3] = warn_en & (feedback_i > fb_ceil_reg);

    wire term_now = |(warn_reg & route_reg[3:0]);
    wire [1:0] relay_now = {|(warn_reg & route_reg[11:8]), |(warn_reg & route_reg[7:4])};

    // events: rising edge of each warning and fill completion
    wire fill_done_ev = state_reg == ST_FILL && state_next != ST_FILL && fill_reached;
    wire [4:0] events = {fill_done_ev, warn_reg & ~warn_prev_reg};

    ////////////////////////////////////////////////////////////////////
    // sequencer

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_STOP: begin
                if (start_cmd) begin
                    state_next = (init_on && !at_min) ? ST_INIT_RAMP : ST_RAMP_UP;
                end
            end
            ST_INIT_RAMP: begin
                if (!start_cmd) begin
                    state_next = ST_RAMP_DOWN;
                end else if (at_min) begin
                    state_next = fill_ok ? ST_FILL : ST_RAMP_UP;
                end
            end
            ST_RAMP_UP: begin
                if (!start_cmd) begin
                    state_next = ST_RAMP_DOWN;
                end else if (fill_ok && !filled_once_reg && at_min) begin
                    state_next = ST_FILL;
                end else if (at_ref) begin
                    state_next = ST_RUN;
                end
            end
            ST_FILL: begin
                if (!start_cmd) begin
                    state_next = ST_RAMP_DOWN;
                end else if (fill_reached) begin
                    state_next = ST_RAMP_UP;
                end
            end
            ST_RUN: begin
                if (!start_cmd) begin
                    state_next = ST_RAMP_DOWN;
                end else if (!at_ref) begin
                    state_next = ST_RAMP_UP;
                end
            end
            ST_RAMP_DOWN: begin
                if (start_cmd) begin
                    state_next = ST_RAMP_UP;
                end else if (stopped) begin
                    state_next = ST_STOP;
                end
            end
            default: state_next = ST_STOP;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ST_STOP;
            filled_once_reg <= 1'b0;
        end else if (ce_i) begin
            state_reg <= state_next;
            if (state_reg == ST_STOP) begin
                filled_once_reg <= 1'b0;
            end else if (fill_done_ev) begin
                filled_once_reg <= 1'b1;
            end
        end
    end

    // pressure target in micro-units, stepped once per millisecond
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            target_reg <= 48'sh0;
            tick_cnt_reg <= 32'h0;
        end else if (ce_i) begin
            tick_cnt_reg <= tick ? 32'h0 : tick_cnt_reg + 32'h1;
            if (state_reg != ST_FILL && state_next == ST_FILL) begin
                target_reg <= 48'(feedback_i) * `MICRO_PER_MILLI;
                tick_cnt_reg <= 32'h0;
            end else if (state_reg == ST_FILL && tick) begin
                target_reg <= (target_step > filled_fine) ? filled_fine : target_step;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // warnings and outputs; flags follow their condition each cycle

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            warn_reg <= 4'h0;
            warn_prev_reg <= 4'h0;
            term_reg <= 1'b0;
            relay_reg <= 2'h0;
            setpoint_reg <= 32'sh0;
        end else if (ce_i) begin
            warn_reg <= warn_now;
            warn_prev_reg <= warn_reg;
            term_reg <= term_now;
            relay_reg <= relay_now;
            setpoint_reg <= (state_reg == ST_FILL) ? target_out : op_sp;
        end
    end

    assign ref_under_flag_o = warn_reg[0];
    assign ref_over_flag_o = warn_reg[1];
    assign feedback_under_flag_o = warn_reg[2];
    assign feedback_over_flag_o = warn_reg[3];
    assign term_o = term_reg;
    assign relay_o = relay_reg;
    assign setpoint_o = setpoint_reg;
    assign init_ramp_active_o = state_reg == ST_INIT_RAMP;
    assign init_ramp_time_o = init_ramp_reg[11:0];
    assign fill_active_o = state_reg == ST_FILL;
    assign irq_o = |(irq_stat_reg & irq_mask_reg);

    ////////////////////////////////////////////////////////////////////
    // register writes; a new event beats a write-one clear

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= 5'h0;
            irq_stat_reg <= 5'h0;
            irq_mask_reg <= 5'h0;
            route_reg <= 12'h0;
        end else if (ce_i) begin
            if (wr && sel_ctrl) begin
                ctrl_reg <= dat_i[4:0];
            end
            if (wr && sel_imask) begin
                irq_mask_reg <= dat_i[4:0];
            end
            if (wr && sel_route) begin
                route_reg <= dat_i[11:0];
            end
            irq_stat_reg <= (irq_stat_reg & ~((wr && sel_istat) ? dat_i[4:0] : 5'h0)) | events;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_low_reg <= `VAL_MIN;
            ref_high_reg <= `VAL_MAX;
            fb_floor_reg <= `VAL_MIN;
            fb_ceil_reg <= `VAL_MAX;
            init_ramp_reg <= 32'sh0;
            min_freq_reg <= 32'sh0;
            fill_rate_reg <= 32'sh0;
            filled_sp_reg <= 32'sh0;
            sp1_reg <= 32'sh0;
            sp2_reg <= 32'sh0;
            fb_min_reg <= 32'sh0;
            ref_max_reg <= `VAL_MAX;
        end else if (ce_i && wr) begin
            if (sel_rlow) ref_low_reg <= w_rlow;
            if (sel_rhigh) ref_high_reg <= w_rhigh;
            if (sel_ffloor) fb_floor_reg <= w_ffloor;
            if (sel_fceil) fb_ceil_reg <= w_fceil;
            if (sel_iramp) init_ramp_reg <= w_iramp;
            if (sel_minf) min_freq_reg <= w_generic;
            if (sel_frate) fill_rate_reg <= w_frate;
            if (sel_fsp) filled_sp_reg <= w_fsp;
            if (sel_sp1) sp1_reg <= w_generic;
            if (sel_sp2) sp2_reg <= w_generic;
            if (sel_fbmin) fb_min_reg <= w_generic;
            if (sel_rmax) ref_max_reg <= w_generic;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read path; unmapped addresses answer with zero

    wire [31:0] status_word = {27'h0, !init_on, state_reg, warn_reg[3:0] != 4'h0};
    wire [31:0] rd_mux =
        sel_ctrl ? 32'(ctrl_reg) :
        sel_status ? status_word :
        sel_istat ? 32'(irq_stat_reg) :
        sel_imask ? 32'(irq_mask_reg) :
        sel_rlow ? ref_low_reg :
        sel_rhigh ? ref_high_reg :
        sel_ffloor ? fb_floor_reg :
        sel_fceil ? fb_ceil_reg :
        sel_iramp ? init_ramp_reg :
        sel_minf ? min_freq_reg :
        sel_frate ? fill_rate_reg :
        sel_fsp ? filled_sp_reg :
        sel_sp1 ? sp1_reg :
        sel_sp2 ? sp2_reg :
        sel_fbmin ? fb_min_reg :
        sel_rmax ? ref_max_reg :
        sel_route ? 32'(route_reg) : 32'h0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0;
        end else if (ce_i) begin
            ack_reg <= req;
            if (req && !we_i) begin
                dat_reg <= rd_mux;
            end
        end
    end

    assign ack_o = ack_reg;
    assign dat_o = dat_reg;

endmodule
`default_nettype wire

// >>> drive_limit_chk.sv
// port checker for the limit warning and fill sequencer
// assumes one clock domain and a synchronous high reset
`timescale 1ns/10ps
`default_nettype none
module drive_limit_chk
    import drive_limit_pkg::*;
(
    input wire logic clk_i, // clock
    input wire logic rst_i, // reset
    input wire logic ce_i, // enable
    input wire logic cyc_i, // cycle
    input wire logic stb_i, // strobe
    input wire logic ack_o, // ack
    input wire value_t out_freq_i, // frequency
    input wire value_t freq_ref_i, // tracked
    input wire logic ref_under_flag_o, // ref low
    input wire logic ref_over_flag_o, // ref high
    input wire logic feedback_under_flag_o, // feedback_floor_threshold
    input wire logic feedback_over_flag_o, // feedback_ceiling_threshold
    input wire logic term_o, // terminal
    input wire logic [1:0] relay_o, // relays
    input wire logic init_ramp_active_o, // init ramp
    input wire logic [11:0] init_ramp_time_o, // ramp time
    input wire logic fill_active_o // fill
);
    wire logic any_flag = ref_under_flag_o | ref_over_flag_o | feedback_under_flag_o | feedback_over_flag_o;
    wire logic reached = (out_freq_i == freq_ref_i);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////
    a_ack_answer: assert property (cyc_i && stb_i && !ack_o && ce_i |=> ack_o) else $error("ack missing");
    a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
    a_fb_excl: assert property (!(feedback_under_flag_o && feedback_over_flag_o))
        else $error("both feedback flags high");
    // two edges: reached to state, state to flag
    a_warn_reached: assert property (any_flag |-> $past(reached, 2))
        else $error("warning before reached");
    a_fill_quiet: assert property (fill_active_o [*2] |-> !any_flag)
        else $error("warning in fill");
    a_init_quiet: assert property (init_ramp_active_o && $past(init_ramp_active_o) |-> !any_flag)
        else $error("warning in init ramp");
    a_term_cause: assert property (term_o |-> $past(any_flag)) else $error("terminal without warning");
    a_relay_cause: assert property (relay_o != 2'h0 |-> $past(any_flag))
        else $error("relay without warning");
    a_init_off: assert property ($rose(init_ramp_active_o) |-> $past(init_ramp_time_o) != 12'h000)
        else $error("initial ramp while off");
    a_init_range: assert property (init_ramp_time_o <= 12'he10) else $error("ramp time out of range");
    a_mode_excl: assert property (!(init_ramp_active_o && fill_active_o)) else $error("init ramp and fill");
    c_fill: cover property ($rose(fill_active_o));
    c_init: cover property (init_ramp_active_o);
    c_warn: cover property (feedback_over_flag_o && term_o);
endmodule
bind drive_limit_warn_fill_ramp drive_limit_chk u_chk (
    .clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .ack_o, .out_freq_i, .freq_ref_i, .ref_under_flag_o, .ref_over_flag_o,
    .feedback_under_flag_o, .feedback_over_flag_o, .term_o, .relay_o, .init_ramp_active_o, .init_ramp_time_o,
    .fill_active_o
);
`default_nettype wire

// >>> motor_pump_model.sv
// motor, pump and pressure sensor stand-in
// assumes the bench asks for speed only while the drive runs
`timescale 1ns/10ps
`default_nettype none
module motor_pump_model
    import drive_limit_pkg::*;
#(
    parameter int STEP = 100
) (
    input wire logic clk_i, // clock
    input wire logic rst_i, // reset
    input wire logic slow_i, // sluggish motor
    input wire value_t speed_cmd_i, // asked frequency
    input wire value_t press_i, // pipe pressure
    output value_t out_freq_o, // shaft frequency
    output value_t freq_ref_o, // tracked frequency
    output value_t feedback_o // sensor reading
);
    wire value_t step = slow_i ? 32'sh1 : value_t'(STEP);
    ////////////////////////////////////////////////////////////////
    // sensor lags one cycle, as a real transducer would
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_freq_o <= '0;
            freq_ref_o <= '0;
            feedback_o <= '0;
        end else begin
            freq_ref_o <= speed_cmd_i;
            feedback_o <= press_i;
            if (out_freq_o + step <= speed_cmd_i) out_freq_o <= out_freq_o + step;
            else if (out_freq_o - step >= speed_cmd_i) out_freq_o <= out_freq_o - step;
            else out_freq_o <= speed_cmd_i;
        end
    end
endmodule
`default_nettype wire

// >>> test_drive_limit_warn_fill_ramp.sv
// self-checking bench for limit warnings, initial ramp and fill
// assumes the motor model drives frequency and feedback
`timescale 1ns/10ps
`default_nettype none
`include "drive_limit_cfg.svh"
module test_drive_limit_warn_fill_ramp
    import drive_limit_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, slow = 1'b0;
    logic [3:0] sel = 4'hf;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    value_t remote_ref = '0, result_ref = '0, press = '0, speed = '0;
    logic [31:0] rdat, q;
    logic ack, ruf, rof, fuf, fof, term, irq, init_act, fill_act;
    logic [1:0] relay;
    logic [11:0] init_time;
    value_t out_freq, freq_ref, feedback, setpoint;
    wire [3:0] flags = {fof, fuf, rof, ruf};
    int n_mismatch = 0, comparisons = 0, seen = 0, expv, i;
    localparam logic [7:0] RA [7] = '{`ADR_REF_LOW, `ADR_REF_HIGH, `ADR_FB_FLOOR, `ADR_FB_CEIL, `ADR_INIT_RAMP,
        `ADR_STATUS, 8'h44};
    localparam logic [31:0] RE [7] = '{`VAL_MIN, `VAL_MAX, `VAL_MIN, `VAL_MAX, 32'h0, 32'h10, 32'h0};
    localparam logic [7:0] WA [11] = '{`ADR_FB_CEIL, `ADR_FB_FLOOR, `ADR_FB_FLOOR, `ADR_FB_FLOOR, `ADR_REF_HIGH,
        `ADR_REF_LOW, `ADR_INIT_RAMP, `ADR_FILL_RATE, `ADR_FILL_RATE, `ADR_FILLED_SP, 8'h44};
    localparam logic [31:0] WD [11] = '{32'h1388, 32'h2328, 32'h80000000, 32'h3e8, 32'hbb8, 32'h3e8, 32'hfa0,
        32'hffffffff, 32'h7fffffff, 32'h3039, 32'h7};
    localparam logic [31:0] WE [11] = '{32'h1388, 32'h1388, `VAL_MIN, 32'h3e8, 32'hbb8, 32'h3e8, 32'he10, 32'h0,
        `VAL_MAX, 32'h3034, 32'h0};
    always #4 clk = ~clk;
    drive_limit_warn_fill_ramp #(.FILL_TICK_CYC(10)) uut (
        .clk_i(clk), .rst_i(rst), .ce_i(1'b1), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .dat_i(wdat), .sel_i(sel), .dat_o(rdat), .ack_o(ack), .remote_ref_i(remote_ref),
        .result_ref_i(result_ref), .feedback_i(feedback), .out_freq_i(out_freq), .freq_ref_i(freq_ref),
        .ref_under_flag_o(ruf), .ref_over_flag_o(rof), .feedback_under_flag_o(fuf),
        .feedback_over_flag_o(fof), .term_o(term), .relay_o(relay), .init_ramp_active_o(init_act),
        .init_ramp_time_o(init_time), .fill_active_o(fill_act), .setpoint_o(setpoint), .irq_o(irq)
    );
    motor_pump_model motor (.clk_i(clk), .rst_i(rst), .slow_i(slow), .speed_cmd_i(speed),
        .press_i(press), .out_freq_o(out_freq), .freq_ref_o(freq_ref), .feedback_o(feedback));
    ////////////////////////////////////////////////////////////////
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic final_report();
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h65fd));
        tick(16);
        rst <= 1'b0;
        for (i = 0; i < 7; i++) begin
            wb(1'b0, RA[i], 32'h0);
            chk(q, RE[i]);
        end
        for (i = 0; i < 11; i++) begin
            wb(1'b1, WA[i], WD[i]);
            wb(1'b0, WA[i], 32'h0);
            chk(q, WE[i]);
        end
        chk(init_time, 32'he10);
        wb(1'b1, `ADR_INIT_RAMP, 32'ha);
        wb(1'b1, `ADR_MIN_FREQ, 32'h1f4);
        wb(1'b1, `ADR_ROUTE, 32'hf0f);
        wb(1'b1, `ADR_IRQ_MASK, 32'hf);
        wb(1'b1, `ADR_CTRL, 32'h3);
        speed <= 32'h7d0;
        chk(init_act, 1'b1);
        chk(flags, 32'h0);
        for (i = 0; i < 100 && out_freq < 32'h1f4; i++) @(posedge clk);
        tick(3);
        chk(init_act, 1'b0);
        chk(flags, 32'h0);
        for (i = 0; i < 100 && out_freq != 32'h7d0; i++) @(posedge clk);
        tick(3);
        chk(flags, 32'h5);
        seen = 5;
        // remote off only on neutral inputs
        for (i = 0; i < 40; i++) begin
            if (i == 28) begin
                remote_ref <= 32'h7d0;
                result_ref <= 32'h7d0;
                press <= 32'hbb8;
                tick(4);
                wb(1'b1, `ADR_CTRL, 32'h1);
            end
            remote_ref <= $urandom_range(4000);
            result_ref <= $urandom_range(4000);
            press <= $urandom_range(6000);
            tick(4);
            expv = {press > 32'h1388, press < 32'h3e8, i < 28 && result_ref > 32'hbb8, i < 28 && remote_ref < 32'h3e8};
            seen |= expv;
            chk(flags, expv);
            chk({term, relay}, {|expv, |expv, 1'b0});
        end
        chk(irq, seen != 0);
        wb(1'b0, `ADR_IRQ_STAT, 32'h0);
        chk(q, seen);
        press <= 32'hbb8;
        tick(4);
        wb(1'b1, `ADR_IRQ_STAT, 32'h1f);
        chk(irq, 1'b0);
        wb(1'b1, `ADR_IRQ_MASK, 32'h0);
        press <= '0;
        tick(4);
        chk(irq, 1'b0);
        wb(1'b1, `ADR_IRQ_MASK, 32'h4);
        chk(irq, 1'b1);
        wb(1'b1, `ADR_CTRL, 32'h0);
        speed <= '0;
        tick(4);
        chk({flags, term}, 32'h0);
        for (i = 0; i < 100 && out_freq != 0; i++) @(posedge clk);
        tick(3);
        chk(flags, 32'h0);
        wb(1'b1, `ADR_INIT_RAMP, 32'h0);
        wb(1'b1, `ADR_FILL_RATE, 32'h1388);
        wb(1'b1, `ADR_FILLED_SP, 32'h7d0);
        wb(1'b1, `ADR_SP1, 32'h1b58);
        wb(1'b1, `ADR_SP2, 32'h1f40);
        press <= 32'h3e8;
        slow <= 1'b1;
        wb(1'b1, `ADR_CTRL, 32'hd);
        speed <= 32'h7d0;
        for (i = 0; i < 2000 && out_freq < 32'h2bc; i++) @(posedge clk);
        chk(fill_act, 1'b0);
        wb(1'b1, `ADR_CTRL, 32'h0);
        speed <= '0;
        slow <= 1'b0;
        for (i = 0; i < 2000 && out_freq != 0; i++) @(posedge clk);
        tick(3);
        wb(1'b1, `ADR_CTRL, 32'h5);
        speed <= 32'h7d0;
        for (i = 0; i < 200 && fill_act !== 1'b1; i++) @(posedge clk);
        chk({fill_act, out_freq >= 32'h1f4}, 32'h3);
        tick(3);
        chk(setpoint >= 32'h3e8 && setpoint <= 32'h3ed, 1'b1);
        tick(100);
        chk(setpoint >= 32'h415 && setpoint <= 32'h424, 1'b1);
        press <= 32'h7d0;
        for (i = 0; i < 50 && fill_act !== 1'b0; i++) @(posedge clk);
        tick(3);
        chk(setpoint, 32'h1b58);
        wb(1'b0, `ADR_IRQ_STAT, 32'h0);
        chk(q[4], 1'b1);
        wb(1'b1, `ADR_CTRL, 32'h15);
        tick(2);
        chk(setpoint, 32'h1f40);
        final_report();
    end
    initial begin
        tick(20000);
        n_mismatch++;
        final_report();
    end
endmodule
`default_nettype wire
